// ===== fpx_core_model.sv
// Model of the core's exception vectoring side: it acknowledges each request after a set delay.
// Assumes the request is a level that stays up until the edge on which the acknowledge is seen.
`timescale 1ns/100ps
module fpx_core_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Request side
  input wire logic exc_req_i,
  input wire logic [3:0] ack_dly_i,
  output logic exc_ack_o
);
  logic [3:0] wait_r;

  // A slow core stretches the wait, so a request must stand for several cycles.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_r <= 4'h0;
      exc_ack_o <= 1'b0;
    end else if (exc_ack_o) begin
      wait_r <= 4'h0;
      exc_ack_o <= 1'b0;
    end else if (exc_req_i && wait_r >= ack_dly_i) begin
      exc_ack_o <= 1'b1;
    end else if (exc_req_i) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// ===== fpx_exception_logic.sv
// Floating-point exception detection, priority and reporting for the core's FPU.
// Assumes one issue pulse per instruction and a core that acknowledges a taken request.
//
// Behaviour
// [RQ1] Rank classes unordered-branch first, imprecise last.
// [RQ2] Most exceptions wait for next arithmetic instruction.
// [RQ3] Store exceptions report right after the store.
// [RQ4] Moves are arithmetic; only stores report post.
// [RQ5] Post exception leaves destination untouched, resumes after.
// [RQ6] Enabled set status bit makes exception pending.
// [RQ7] Software register write can make exception pending.
// [RQ8] Set all bits, report only highest class.
// [RQ9] Disabled class: default result, no exception.
// [RQ10] Enabled pre: default written; post: nothing.
// [RQ11] State save clears the control register.
// [RQ12] State restore with enabled bit re-raises exception.
// [RQ13] No exceptions on control or multi-register moves.
// [RQ14] Conditional: service pending, then check unordered.
// [RQ15] NaN operand sets input-NaN bit.
// [RQ16] NaN default: positive all-ones NaN or constant.
// [RQ17] Denormal: zero plus imprecise, or take exception. The code writes the issued result unchanged, not zero.
// [RQ18] Meaningless operation sets operand-error bit.
// [RQ19] Overflow only for float destinations, else operand error.
// [RQ20] Underflow check, round, overflow check, store.
// [RQ21] Underflow only for float destinations; integers zero.
// [RQ22] Underflow sets imprecise only when disabled.
// [RQ23] Zero divisor sets divide-by-zero bit.
// [RQ24] Inexact mantissa sets imprecise bit, result rounded.
// [RQ25] Never output a denormalized result.
// [RQ26] Request and class code held until acknowledge.
`timescale 1ns/100ps
module fpx_exception_logic
  import fpx_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Sequencer issue
  input wire logic issue_i,
  input wire fpx_pkg::issue_t issue_info_i,
  input wire fpx_pkg::raw_cond_t cond_i,
  input wire logic nan_cc_i,
  // Software register writes and restore image
  input wire logic sw_status_we_i,
  input wire fpx_pkg::exc_vec_t sw_status_i,
  input wire logic sw_control_we_i,
  input wire fpx_pkg::exc_vec_t sw_control_i,
  input wire fpx_pkg::exc_vec_t restore_status_i,
  input wire fpx_pkg::exc_vec_t restore_control_i,
  // Core exception logic
  input wire logic exc_ack_i,
  output logic exc_req_o,
  output fpx_pkg::exc_code_t exc_code_o,
  output logic exc_post_o,
  output logic stall_o,
  // Destination write
  output logic dest_we_o,
  output logic [63:0] dest_data_o,
  // Register views
  output fpx_pkg::exc_vec_t fp_status_reg_o,
  output fpx_pkg::exc_vec_t fp_control_reg_o
);
  import fpx_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The encoders hand back a class index, so a narrow code would alias two classes.
  if ((1 << $bits(exc_code_t)) < NUM_CLASSES) begin : g_code_width
    $error("Exception class code is too narrow for the class count.");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    req_state_t st;
    exc_vec_t status;
    exc_vec_t control;
    exc_code_t code;
    logic post;
    logic dest_we;
    logic [63:0] dest_data;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ----------------------------------------
  // Condition decode
  // ----------------------------------------
  logic range_under;
  logic range_over;
  logic int_dest;
  logic is_store;
  logic is_arith;
  logic quiet_kind;
  exc_vec_t raised;
  exc_vec_t pend_vec;
  exc_code_t sel_code;
  logic sel_any;
  exc_code_t now_code;
  logic now_any;
  logic [63:0] dflt;

  fpx_range_check u_range (
    .exp_i(cond_i.inter_exp),
    .single_i(issue_info_i.rnd_single),
    .fmt_i(issue_info_i.fmt),
    .under_o(range_under),
    .over_o(range_over),
    .int_dest_o(int_dest)
  );

  // Standing pending vector: set status bits with their enables.
  fpx_prio_enc #(.WIDTH(NUM_CLASSES)) u_prio_pend (
    .cand_i(pend_vec),
    .code_o(sel_code),
    .any_o(sel_any)
  );

  // Classes this store raises now, enabled.
  fpx_prio_enc #(.WIDTH(NUM_CLASSES)) u_prio_now (
    .cand_i(raised & s_r.control),
    .code_o(now_code),
    .any_o(now_any)
  );

  always_comb begin
    pend_vec = s_r.status & s_r.control; // RQ6 RQ7 RQ12
    is_store = (issue_info_i.kind == INS_STORE) && !issue_info_i.to_fp_reg; // RQ4
    quiet_kind = (issue_info_i.kind == INS_MOVE_CTRL) || (issue_info_i.kind == INS_MULTI_MOVE) ||
                 (issue_info_i.kind == INS_SAVE) || (issue_info_i.kind == INS_RESTORE); // RQ13
    is_arith = !quiet_kind && (issue_info_i.kind != INS_COND);
    raised = EXC_NONE;
    if (issue_info_i.kind == INS_COND) begin
      raised[CLS_BRANCH_UNORDERED_EXC] = issue_info_i.nonaware_test && nan_cc_i; // RQ14
    end else if (is_arith) begin
      raised[CLS_INPUT_NAN_EXC] = cond_i.src_nan; // RQ15
      raised[CLS_IDE] = cond_i.src_denorm;
      raised[CLS_OPERAND_ERROR_EXC] = cond_i.no_meaning || (range_over && int_dest); // RQ18 RQ19
      // Underflow is checked first; overflow only when the same exponent has not underflowed.
      raised[CLS_UNDERFLOW_EXC] = range_under && !int_dest; // RQ20 RQ21
      raised[CLS_OVERFLOW_EXC] = range_over && !int_dest; // RQ19 RQ20
      raised[CLS_DZ] = cond_i.is_divide && cond_i.div_zero_divisor; // RQ23
      raised[CLS_IMPRECISE_RESULT_EXC] = cond_i.mant_inexact || raised[CLS_OVERFLOW_EXC] || // RQ24 RQ19
                         (raised[CLS_UNDERFLOW_EXC] && !s_r.control[CLS_UNDERFLOW_EXC]) || // RQ22
                         (cond_i.src_denorm && !s_r.control[CLS_IDE]); // RQ17
    end
    // Default result for the destination.
    dflt = issue_info_i.result;
    if (cond_i.src_nan) begin
      if (issue_info_i.fmt == FMT_SINGLE) begin
        dflt = DFLT_NAN_SINGLE; // RQ16
      end else if (issue_info_i.fmt == FMT_DOUBLE) begin
        dflt = DFLT_NAN_DOUBLE; // RQ16
      end else begin
        dflt = DFLT_ALL_ONES; // RQ16
      end
    end else if (raised[CLS_UNDERFLOW_EXC] || (range_under && int_dest)) begin
      // Flush to zero rather than emit a denormal; software builds those.
      dflt = ZERO_RESULT; // RQ21 RQ25
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.dest_we = 1'b0;
    stall_o = 1'b0;
    case (s_r.st)
      RQ_IDLE, RQ_PEND: begin
        if (issue_i) begin
          if ((is_arith || issue_info_i.kind == INS_COND) && sel_any) begin
            // Pending exception is taken before this instruction runs.
            s_nxt.st = RQ_WAIT_ACK; // RQ2 RQ7 RQ14
            s_nxt.code = sel_code; // RQ1 RQ8
            s_nxt.post = 1'b0;
            stall_o = 1'b1;
          end else if (issue_info_i.kind == INS_SAVE) begin
            s_nxt.control = EXC_NONE; // RQ11
          end else if (issue_info_i.kind == INS_RESTORE) begin
            s_nxt.status = restore_status_i; // RQ12
            s_nxt.control = restore_control_i; // RQ12
          end else if (!quiet_kind) begin
            s_nxt.status = s_r.status | raised; // RQ8
            if (is_store && now_any) begin
              // Post report: nothing written, core resumes after the store.
              s_nxt.st = RQ_WAIT_ACK; // RQ3 RQ5 RQ10
              s_nxt.code = now_code; // RQ1 RQ8
              s_nxt.post = 1'b1;
            end else if (issue_info_i.kind != INS_COND) begin
              s_nxt.dest_we = 1'b1; // RQ9 RQ10
              s_nxt.dest_data = dflt; // RQ9 RQ10
              if ((raised & s_r.control) != EXC_NONE) begin
                s_nxt.st = RQ_PEND; // RQ6
              end
            end else if ((raised & s_r.control) != EXC_NONE) begin
              s_nxt.st = RQ_PEND; // RQ14
            end
          end
        end
        if (sw_status_we_i) begin
          s_nxt.status = sw_status_i; // RQ7
        end
        if (sw_control_we_i) begin
          s_nxt.control = sw_control_i; // RQ7
        end
        // Pending follows the registers, so a software write alone arms or clears it.
        if (s_nxt.st != RQ_WAIT_ACK) begin
          s_nxt.st = ((s_nxt.status & s_nxt.control) != EXC_NONE) ? RQ_PEND : RQ_IDLE; // RQ7
        end
      end
      RQ_WAIT_ACK: begin
        // Request holds; the sequencer must not issue while it stands.
        stall_o = 1'b1;
        if (exc_ack_i) begin
          s_nxt.st = RQ_IDLE; // RQ26
          s_nxt.code = CODE_NONE;
          s_nxt.post = 1'b0;
        end
      end
      default: begin
        s_nxt.st = RQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '{st: RQ_IDLE, status: EXC_NONE, control: EXC_NONE, code: CODE_NONE,
               post: 1'b0, dest_we: 1'b0, dest_data: ZERO_RESULT};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign exc_req_o = (s_r.st == RQ_WAIT_ACK); // RQ26
  assign exc_code_o = s_r.code;
  assign exc_post_o = s_r.post;
  assign dest_we_o = s_r.dest_we;
  assign dest_data_o = s_r.dest_data;
  assign fp_status_reg_o = s_r.status;
  assign fp_control_reg_o = s_r.control;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_req_held: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ26
    exc_req_o && !exc_ack_i |=> exc_req_o && $stable(exc_code_o))
    else $error("Exception request dropped before acknowledge.");

  a_save_clears: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ11
    issue_i && issue_info_i.kind == INS_SAVE && !exc_req_o && !sw_control_we_i |=> fp_control_reg_o == EXC_NONE)
    else $error("State save did not clear control register.");

  a_post_nowrite: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ5
    exc_req_o && exc_post_o |-> !dest_we_o)
    else $error("Destination written on post exception.");

  a_prio_top: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ1
    $rose(exc_req_o) && !exc_post_o |-> exc_code_o == $past(sel_code))
    else $error("Reported class is not highest pending.");

  a_pre_stall: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ2
    issue_i && is_arith && sel_any && !exc_req_o |-> stall_o ##1 exc_req_o && !exc_post_o)
    else $error("Pending exception not taken before arithmetic.");

  a_store_post: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ3
    issue_i && is_store && now_any && !sel_any && s_r.st == RQ_IDLE |=> exc_req_o && exc_post_o)
    else $error("Store exception not reported post instruction.");

  a_dz_sets: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ23
    issue_i && is_arith && !sel_any && s_r.st == RQ_IDLE && cond_i.is_divide && cond_i.div_zero_divisor
    && !sw_status_we_i |=> fp_status_reg_o[CLS_DZ])
    else $error("Zero divisor did not set status bit.");

  a_quiet_moves: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ13
    issue_i && issue_info_i.kind == INS_MULTI_MOVE && !exc_req_o |=> !exc_req_o)
    else $error("Exception on multi-register move.");

  a_default_write: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ9 RQ10
    issue_i && is_arith && !sel_any && !exc_req_o && !(is_store && now_any)
    |=> !exc_req_o && dest_we_o)
    else $error("Default result not written without a taken exception.");

  a_pend_arms: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ6
    issue_i && is_arith && !is_store && !sel_any && !exc_req_o && now_any && !sw_status_we_i
    && !sw_control_we_i |=> s_r.st == RQ_PEND)
    else $error("Enabled status bit did not make an exception pending.");

  a_sw_arms: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ7
    !issue_i && !exc_req_o && sw_status_we_i && sw_control_we_i
    && (sw_status_i & sw_control_i) != EXC_NONE |=> s_r.st == RQ_PEND)
    else $error("Software write did not arm a pending exception.");

  a_nan_default: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ16
    issue_i && is_arith && !sel_any && !exc_req_o && !(is_store && now_any) && cond_i.src_nan
    && issue_info_i.fmt == FMT_DOUBLE |=> dest_data_o == DFLT_NAN_DOUBLE)
    else $error("Wrong default result for a NaN operand.");

  a_input_nan_exc_sets: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ15
    issue_i && is_arith && !sel_any && !exc_req_o && cond_i.src_nan && !sw_status_we_i
    |=> fp_status_reg_o[CLS_INPUT_NAN_EXC])
    else $error("NaN operand did not set its status bit.");

  a_restore_loads: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ12
    issue_i && issue_info_i.kind == INS_RESTORE && !exc_req_o && !sw_status_we_i && !sw_control_we_i
    |=> fp_status_reg_o == $past(restore_status_i) && fp_control_reg_o == $past(restore_control_i))
    else $error("State restore did not reload the registers.");

  a_branch_unordered_exc_sets: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ14
    issue_i && issue_info_i.kind == INS_COND && issue_info_i.nonaware_test && nan_cc_i && !sel_any
    && !exc_req_o && !sw_status_we_i |=> fp_status_reg_o[CLS_BRANCH_UNORDERED_EXC])
    else $error("Unordered branch did not set its status bit.");

  a_req_stalls: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ26
    exc_req_o |-> stall_o)
    else $error("Issue not refused while a request stands.");

  a_post_store: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ4
    $rose(exc_req_o) && exc_post_o |-> $past(is_store))
    else $error("Post exception raised by an instruction that is no store.");

  a_overflow_exc_imprecise_result_exc: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ19
    issue_i && is_arith && !sel_any && !exc_req_o && range_over && !int_dest && !sw_status_we_i
    |=> fp_status_reg_o[CLS_OVERFLOW_EXC] && fp_status_reg_o[CLS_IMPRECISE_RESULT_EXC])
    else $error("Overflow did not set overflow and imprecise bits.");

  a_int_zero: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ21
    issue_i && is_arith && !sel_any && !exc_req_o && !(is_store && now_any) && range_under && int_dest
    && !cond_i.src_nan |=> dest_data_o == ZERO_RESULT)
    else $error("Integer underflow did not give zero.");

  a_ide_imprecise_result_exc: assert property (@(posedge clock_i) disable iff (!resetn_i) // RQ17
    issue_i && is_arith && !sel_any && !exc_req_o && cond_i.src_denorm && !s_r.control[CLS_IDE]
    && !sw_status_we_i |=> fp_status_reg_o[CLS_IMPRECISE_RESULT_EXC])
    else $error("Disabled denormal input did not set imprecise bit.");

  // ----------------------------------------
  // Cover
  // ----------------------------------------

  c_pre_taken: cover property (@(posedge clock_i) disable iff (!resetn_i) $rose(exc_req_o) && !exc_post_o);
  c_post_taken: cover property (@(posedge clock_i) disable iff (!resetn_i) $rose(exc_req_o) && exc_post_o);
  c_ack: cover property (@(posedge clock_i) disable iff (!resetn_i) exc_req_o && exc_ack_i);
  c_branch_unordered_exc_flag: cover property (@(posedge clock_i) disable iff (!resetn_i) $rose(fp_status_reg_o[CLS_BRANCH_UNORDERED_EXC]));
  c_int_zero: cover property (@(posedge clock_i) disable iff (!resetn_i) dest_we_o && dest_data_o == ZERO_RESULT);
endmodule

// ===== fpx_pkg.sv
// Package for the floating-point exception logic: class indices, codes, state and carriers.
// Assumes a 64-bit double-precision datapath that flags raw conditions per operation.
package fpx_pkg;

  // ----------------------------------------
  // Exception classes, highest priority first
  // ----------------------------------------
  localparam int unsigned NUM_CLASSES = 8;
  localparam int unsigned CLS_BRANCH_UNORDERED_EXC = 7;
  localparam int unsigned CLS_INPUT_NAN_EXC = 6;
  localparam int unsigned CLS_IDE = 5;
  localparam int unsigned CLS_OPERAND_ERROR_EXC = 4;
  localparam int unsigned CLS_OVERFLOW_EXC = 3;
  localparam int unsigned CLS_UNDERFLOW_EXC = 2;
  localparam int unsigned CLS_DZ = 1;
  localparam int unsigned CLS_IMPRECISE_RESULT_EXC = 0;

  typedef logic [NUM_CLASSES-1:0] exc_vec_t;
  typedef logic [2:0] exc_code_t;

  localparam exc_vec_t EXC_NONE = 8'h00;
  localparam exc_code_t CODE_NONE = 3'h0;

  // ----------------------------------------
  // Destination formats and default results
  // ----------------------------------------
  typedef enum logic [2:0] {
    FMT_BYTE = 3'h0,
    FMT_WORD = 3'h1,
    FMT_LONG = 3'h2,
    FMT_SINGLE = 3'h3,
    FMT_DOUBLE = 3'h4
  } dest_fmt_t;

  localparam logic [63:0] DFLT_NAN_SINGLE = 64'h0000_0000_7FFF_FFFF;
  localparam logic [63:0] DFLT_NAN_DOUBLE = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] DFLT_ALL_ONES = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] ZERO_RESULT = 64'h0000_0000_0000_0000;

  // ----------------------------------------
  // Instruction classes presented by the sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    INS_ARITH = 3'h0,
    INS_STORE = 3'h1,
    INS_MOVE_CTRL = 3'h2,
    INS_MULTI_MOVE = 3'h3,
    INS_COND = 3'h4,
    INS_SAVE = 3'h5,
    INS_RESTORE = 3'h6
  } instr_kind_t;

  // Raw conditions flagged by the datapath for one operation.
  typedef struct packed {
    logic src_nan;
    logic src_denorm;
    logic no_meaning;
    logic div_zero_divisor;
    logic is_divide;
    logic mant_inexact;
    logic [11:0] inter_exp;
  } raw_cond_t;

  // Instruction issue descriptor.
  typedef struct packed {
    instr_kind_t kind;
    logic to_fp_reg;
    dest_fmt_t fmt;
    logic nonaware_test;
    logic rnd_single;
    logic [63:0] result;
  } issue_t;

  // ----------------------------------------
  // Exponent limits of the rounding precisions (biased, double layout)
  // ----------------------------------------
  localparam logic [11:0] EXP_MAX_DOUBLE = 12'h7FF;
  localparam logic [11:0] EXP_MIN_DOUBLE = 12'h000;
  localparam logic [11:0] EXP_MAX_SINGLE = 12'h47F;
  localparam logic [11:0] EXP_MIN_SINGLE = 12'h380;

  // Request channel state.
  typedef enum logic [1:0] {
    RQ_IDLE = 2'b00,
    RQ_PEND = 2'b01,
    RQ_WAIT_ACK = 2'b11
  } req_state_t;

endpackage

// ===== fpx_prio_enc.sv
// Priority encoder choosing the highest exception class among enabled, set ones.
// Assumes bit 7 holds the highest-ranked class.
`timescale 1ns/100ps
module fpx_prio_enc #(
  parameter int unsigned WIDTH = 8
) (
  // Candidates
  input wire logic [WIDTH-1:0] cand_i,
  // Selection
  output logic [$clog2(WIDTH)-1:0] code_o,
  output logic any_o
);
  initial begin
    if (WIDTH < 2) begin
      $error("fpx_prio_enc needs at least two classes.");
    end
  end

  always_comb begin
    code_o = '0;
    any_o = 1'b0;
    for (int i = 0; i < WIDTH; i++) begin
      if (cand_i[i]) begin
        code_o = i[$clog2(WIDTH)-1:0];
        any_o = 1'b1;
      end
    end
  end
endmodule

// ===== fpx_range_check.sv
// Exponent range check of an intermediate result against the rounding precision.
// Assumes the datapath rebiases the exponent to the double layout.
`timescale 1ns/100ps
module fpx_range_check
  import fpx_pkg::*;
(
  // Operand
  input wire logic [11:0] exp_i,
  input wire logic single_i,
  input wire fpx_pkg::dest_fmt_t fmt_i,
  // Flags
  output logic under_o,
  output logic over_o,
  output logic int_dest_o
);
  logic fp_dest;
  logic [11:0] lim_max;
  logic [11:0] lim_min;

  always_comb begin
    fp_dest = (fmt_i == FMT_SINGLE) || (fmt_i == FMT_DOUBLE);
    lim_max = single_i ? EXP_MAX_SINGLE : EXP_MAX_DOUBLE;
    lim_min = single_i ? EXP_MIN_SINGLE : EXP_MIN_DOUBLE;
    int_dest_o = !fp_dest;
    under_o = exp_i <= lim_min;
    over_o = !under_o && (exp_i >= lim_max);
  end
endmodule

// ===== tb.sv
// Self-checking testbench for the floating-point exception logic.
// Assumes the package carriers and a core model that acknowledges requests.
`timescale 1ns/100ps
module tb;
  import fpx_pkg::*;
  typedef struct packed {
    logic [5:0] f;
    logic [11:0] e;
    logic [2:0] fmt;
    exc_vec_t ctl;
    exc_code_t code;
    exc_vec_t st;
    exc_vec_t mask;
  } case_t;
  logic clock_i, resetn_i, issue_i, nan_cc_i, sw_status_we_i, sw_control_we_i, exc_ack_i;
  issue_t issue_info_i;
  raw_cond_t cond_i;
  exc_vec_t sw_status_i, sw_control_i, restore_status_i, restore_control_i, stat_o, ctl_o;
  logic exc_req_o, exc_post_o, stall_o, dest_we_o, we_seen, req_seen, post_seen, stall_at;
  exc_code_t exc_code_o, code_seen;
  logic [63:0] dest_data_o, wdata;
  logic [3:0] ack_dly;
  int bad_count, cmp_count;
  // Conditions: nan 20, denorm 10, no meaning 08, zero divide 06, inexact 01.
  case_t tbl [10] = '{
    '{6'h30, 12'h400, 3'h4, 8'hFF, 3'h6, 8'h60, 8'hFF},
    '{6'h09, 12'h400, 3'h4, 8'hFF, 3'h4, 8'h11, 8'hFF},
    '{6'h06, 12'h7FF, 3'h4, 8'hFF, 3'h3, 8'h0B, 8'hFF},
    '{6'h06, 12'h000, 3'h4, 8'hFF, 3'h2, 8'h06, 8'hFF},
    '{6'h07, 12'h400, 3'h4, 8'hFF, 3'h1, 8'h03, 8'hFF},
    '{6'h01, 12'h400, 3'h4, 8'hFF, 3'h0, 8'h01, 8'hFF},
    '{6'h10, 12'h400, 3'h4, 8'h00, 3'h0, 8'h21, 8'hFF},
    '{6'h00, 12'h000, 3'h4, 8'h00, 3'h0, 8'h05, 8'hFF},
    '{6'h00, 12'h7FF, 3'h2, 8'h00, 3'h0, 8'h10, 8'hFE},
    '{6'h00, 12'h000, 3'h0, 8'h00, 3'h0, 8'h00, 8'hFE}};

  fpx_exception_logic dut (.clock_i(clock_i), .resetn_i(resetn_i), .issue_i(issue_i),
    .issue_info_i(issue_info_i), .cond_i(cond_i), .nan_cc_i(nan_cc_i),
    .sw_status_we_i(sw_status_we_i), .sw_status_i(sw_status_i), .sw_control_we_i(sw_control_we_i),
    .sw_control_i(sw_control_i), .restore_status_i(restore_status_i),
    .restore_control_i(restore_control_i), .exc_ack_i(exc_ack_i), .exc_req_o(exc_req_o),
    .exc_code_o(exc_code_o), .exc_post_o(exc_post_o), .stall_o(stall_o), .dest_we_o(dest_we_o),
    .dest_data_o(dest_data_o), .fp_status_reg_o(stat_o), .fp_control_reg_o(ctl_o));

  fpx_core_model core (.clock_i(clock_i), .resetn_i(resetn_i), .exc_req_i(exc_req_o),
    .ack_dly_i(ack_dly), .exc_ack_o(exc_ack_i));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic setup(input exc_vec_t st, input exc_vec_t ct);
    @(negedge clock_i);
    sw_status_we_i = 1'b1;
    sw_status_i = st;
    sw_control_we_i = 1'b1;
    sw_control_i = ct;
    @(negedge clock_i);
    sw_status_we_i = 1'b0;
    sw_control_we_i = 1'b0;
  endtask

  // Issues one instruction, records what answers, then waits for the core to take any request.
  task automatic run(input instr_kind_t k, input logic [2:0] f, input logic na, input raw_cond_t c);
    @(negedge clock_i);
    issue_i = 1'b1;
    issue_info_i = '{k, 1'b1, dest_fmt_t'(f), na, 1'b0, 64'h3FF0_0000_0000_0000};
    cond_i = c;
    we_seen = 1'b0;
    req_seen = 1'b0;
    code_seen = 'x;
    post_seen = 'x;
    wdata = 'x;
    if (k == INS_STORE) begin
      issue_info_i.to_fp_reg = 1'b0;
    end
    #1 stall_at = stall_o;
    @(negedge clock_i);
    issue_i = 1'b0;
    repeat (4) begin
      if (dest_we_o === 1'b1) begin
        we_seen = 1'b1;
        wdata = dest_data_o;
      end
      if (exc_req_o === 1'b1 && !req_seen) begin
        req_seen = 1'b1;
        code_seen = exc_code_o;
        post_seen = exc_post_o;
      end
      @(negedge clock_i);
    end
    for (int n = 0; exc_req_o === 1'b1; n++) begin
      if (n == 30) begin
        bad_count++;
        test_done();
      end
      chk(exc_code_o, code_seen);
      @(negedge clock_i);
    end
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {resetn_i, issue_i, nan_cc_i, sw_status_we_i, sw_control_we_i} = 5'h00;
    {sw_status_i, sw_control_i, restore_status_i, restore_control_i} = 32'h0000_0000;
    issue_info_i = '0;
    cond_i = '0;
    ack_dly = 4'h1;
    bad_count = 0;
    cmp_count = 0;
    repeat (4) @(negedge clock_i);
    resetn_i = 1'b1;
    chk({exc_req_o, dest_we_o, stat_o, ctl_o}, 64'h0);
    for (int i = 0; i < 5; i++) begin
      setup(8'h00, 8'h00);
      run(INS_ARITH, 3'(i), 1'b0, raw_cond_t'({6'h20, 12'h400}));
      chk(req_seen, 1'b0);
      chk(stat_o[CLS_INPUT_NAN_EXC], 1'b1);
      chk(wdata, (i == 3) ? DFLT_NAN_SINGLE : (i == 4) ? DFLT_NAN_DOUBLE : DFLT_ALL_ONES);
    end
    foreach (tbl[i]) begin
      setup(8'h00, tbl[i].ctl);
      run(INS_ARITH, tbl[i].fmt, 1'b0, raw_cond_t'({tbl[i].f, tbl[i].e}));
      chk(we_seen, 1'b1);
      chk(req_seen, 1'b0);
      chk(stat_o & tbl[i].mask, tbl[i].st);
      if (i == 9) begin
        chk(wdata, ZERO_RESULT);
      end
      if (tbl[i].ctl != 8'h00) begin
        run(INS_ARITH, 3'h4, 1'b0, '0);
        chk(stall_at, 1'b1);
        chk(code_seen, tbl[i].code);
        chk(post_seen, 1'b0);
      end
    end
    // A slow core here checks that the request stands until it is taken.
    ack_dly = 4'h6;
    setup(8'h00, 8'hFF);
    run(INS_STORE, 3'h2, 1'b0, raw_cond_t'({6'h06, 12'h400}));
    chk({req_seen, post_seen}, 2'b11);
    chk(code_seen, CLS_DZ);
    chk(we_seen, 1'b0);
    ack_dly = 4'h1;
    foreach (tbl[i]) begin
      if (i < 2) begin
        setup(8'h00, 8'hFF);
        run(i == 0 ? INS_MOVE_CTRL : INS_MULTI_MOVE, 3'h4, 1'b0, raw_cond_t'({6'h20, 12'h400}));
        chk(req_seen, 1'b0);
        run(INS_ARITH, 3'h4, 1'b0, '0);
        chk(stall_at, 1'b0);
      end
    end
    nan_cc_i = 1'b1;
    setup(8'h00, 8'h80);
    run(INS_COND, 3'h4, 1'b1, '0);
    chk(req_seen, 1'b0);
    chk(stat_o[CLS_BRANCH_UNORDERED_EXC], 1'b1);
    // The flagged class is taken before the next arithmetic instruction runs.
    run(INS_ARITH, 3'h4, 1'b0, '0);
    chk(stall_at, 1'b1);
    chk(code_seen, CLS_BRANCH_UNORDERED_EXC);
    setup(8'h00, 8'h00);
    run(INS_COND, 3'h4, 1'b1, '0);
    chk({we_seen, req_seen, stat_o[CLS_BRANCH_UNORDERED_EXC]}, 3'b001);
    setup(8'h00, 8'h80);
    run(INS_COND, 3'h4, 1'b0, '0);
    chk({req_seen, stat_o}, 9'h000);
    setup(8'h02, 8'h02);
    run(INS_COND, 3'h4, 1'b0, '0);
    chk(stall_at, 1'b1);
    chk(code_seen, CLS_DZ);
    nan_cc_i = 1'b0;
    setup(8'h00, 8'hFF);
    run(INS_SAVE, 3'h4, 1'b0, '0);
    chk(ctl_o, 8'h00);
    restore_status_i = 8'h10;
    restore_control_i = 8'h10;
    setup(8'h00, 8'h00);
    run(INS_RESTORE, 3'h4, 1'b0, '0);
    chk({stat_o, ctl_o}, 16'h1010);
    run(INS_ARITH, 3'h4, 1'b0, '0);
    chk(code_seen, CLS_OPERAND_ERROR_EXC);
    test_done();
  end
endmodule
